/* core/ccr_pkg.sv */
package ccr_pkg;
  // Byte addresses on the register bus
  localparam logic [15:0] CCR_ADDR_CFG   = 16'h6330;
  localparam logic [15:0] CCR_ADDR_CMD   = 16'h6340;
  localparam logic [15:0] CCR_ADDR_STAT  = 16'h6344;
  localparam logic [15:0] CCR_ADDR_AUX   = 16'h6348;

  // Clock-pin and probe configuration fields
  localparam int          CCR_CFG_CLKSEL_BIT = 7;
  localparam int          CCR_CFG_PROBE_EN_BIT = 3;
  localparam int          CCR_CFG_SEL_LSB    = 0;
  localparam int          CCR_CFG_SEL_W      = 3;
  localparam logic [7:0]  CCR_CFG_WMASK      = 8'h8f;
  localparam logic [7:0]  CCR_CFG_RESET      = 8'h00;

  // Command register fields
  localparam int          CCR_CMD_CODE_W     = 4;
  localparam int          CCR_CMD_FLUSH_BIT  = 7;
  localparam logic [3:0]  CCR_CMD_IDLE       = 4'h0;

  // Auxiliary pad selectors
  localparam int          CCR_AUX_SEL_W      = 4;
  localparam logic [3:0]  CCR_AUX_PROBE_CODE = 4'ha;
  localparam logic [7:0]  CCR_AUX_RESET      = 8'h00;

  localparam int          CCR_NUM_FAULTS     = 8;

  // Fault line order seen by the probe select field
  typedef enum logic [2:0] {
    CCR_F_PROTOCOL = 3'b000,
    CCR_F_PARITY   = 3'b001,
    CCR_F_CHECKSUM = 3'b010,
    CCR_F_COLLISION = 3'b011,
    CCR_F_OVERFLOW = 3'b100,
    CCR_F_FIELD    = 3'b101,
    CCR_F_OVERHEAT = 3'b110,
    CCR_F_WRITE    = 3'b111
  } ccr_fault_t;
endpackage

/* core/ccr_top.sv */
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
module ccr_top
  import ccr_pkg::*;
(
  input  wire logic        CLK_IN,              // 20 MHz system clock
  input  wire logic        RESET_IN,            // Async reset, active high
  input  wire logic [15:0] AVS_ADDRESS_IN,      // Byte address
  input  wire logic        AVS_READ_IN,         // Read request
  input  wire logic        AVS_WRITE_IN,        // Write request
  input  wire logic [31:0] AVS_WRITEDATA_IN,    // Write data
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,   // Byte enables
  output logic      [31:0] AVS_READDATA_OUT,    // Read data
  output logic             AVS_WAITREQUEST_OUT, // Stall
  input  wire logic        CMD_DONE_IN,         // Command finished pulse
  output logic      [3:0]  CMD_CODE_OUT,        // Active command code
  output logic             FLUSH_PULSE_OUT,     // Write-only strobe
  input  wire logic [7:0]  FAULT_IN,            // Internal fault flags
  input  wire logic        SEC_CLK_IN,          // Secure element clock source
  input  wire logic        GPIO_DATA_IN,        // Port data when in port mode
  input  wire logic        GPIO_OE_N_IN,        // Port enable, low drives
  input  wire logic        PORT_PIN_IN,         // Shared pin level
  output logic             PORT_PIN_OUT,        // Shared pin drive value
  output logic             PORT_PIN_OE_N_OUT,   // Shared pin enable, low drives
  output logic             GPIO_PIN_OUT,        // Pin level back to port logic
  output logic             ERROR_PROBE_OUT,     // Selected fault line
  output logic             AUX1_OUT,            // Auxiliary pad one
  output logic             AUX2_OUT             // Auxiliary pad two
);

  logic [7:0]  cfg_q, cfg_d;
  logic [3:0]  cmd_q, cmd_d;
  logic [7:0]  aux_q, aux_d;
  logic        ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic        flush_q, flush_d;
  logic        pin_q, pin_d;
  logic        oen_q, oen_d;
  logic        gpin_q, gpin_d;
  logic        probe_q, probe_d;
  logic        aux1_q, aux1_d;
  logic        aux2_q, aux2_d;
  logic        req, wr_acc, rd_first;
  logic        wr_cfg, wr_cmd, wr_aux;
  logic [7:0]  rmux;
  logic        probe_sel;

  // One wait cycle per access keeps read data registered
  assign req      = AVS_READ_IN | AVS_WRITE_IN;
  assign wr_acc   = AVS_WRITE_IN & ack_q & AVS_BYTEENABLE_IN[0];
  assign rd_first = AVS_READ_IN & ~ack_q;
  assign wr_cfg   = wr_acc & (AVS_ADDRESS_IN == CCR_ADDR_CFG);
  assign wr_cmd   = wr_acc & (AVS_ADDRESS_IN == CCR_ADDR_CMD);
  assign wr_aux   = wr_acc & (AVS_ADDRESS_IN == CCR_ADDR_AUX);
  assign AVS_WAITREQUEST_OUT = req & ~ack_q;

  always_comb begin
    probe_sel = FAULT_IN[cfg_q[CCR_CFG_SEL_LSB +: CCR_CFG_SEL_W]];
    case (AVS_ADDRESS_IN)
      CCR_ADDR_CFG:  rmux = cfg_q & CCR_CFG_WMASK;
      CCR_ADDR_CMD:  rmux = {4'h0, cmd_q};
      CCR_ADDR_STAT: rmux = FAULT_IN;
      CCR_ADDR_AUX:  rmux = aux_q;
      default:       rmux = 8'h00;
    endcase
  end

  always_comb begin
    ack_d   = req & ~ack_q;
    rdata_d = rd_first ? {24'h0, rmux} : rdata_q;
    // Only the bus touches the control bits
    cfg_d   = wr_cfg ? (AVS_WRITEDATA_IN[7:0] & CCR_CFG_WMASK) : cfg_q;
    aux_d   = wr_aux ? AVS_WRITEDATA_IN[7:0] : aux_q;
    // Write checked last so a new command is never lost to a done pulse
    cmd_d   = CMD_DONE_IN ? CCR_CMD_IDLE : cmd_q;
    if (wr_cmd) begin
      cmd_d = AVS_WRITEDATA_IN[CCR_CMD_CODE_W-1:0];
    end
    flush_d = wr_cmd & AVS_WRITEDATA_IN[CCR_CMD_FLUSH_BIT];
    if (cfg_q[CCR_CFG_CLKSEL_BIT]) begin
      pin_d = SEC_CLK_IN;
      oen_d = 1'b0;
    end else begin
      pin_d = GPIO_DATA_IN;
      oen_d = GPIO_OE_N_IN;
    end
    gpin_d  = PORT_PIN_IN;
    probe_d = probe_sel;
    aux1_d  = cfg_q[CCR_CFG_PROBE_EN_BIT] &
              (aux_q[CCR_AUX_SEL_W-1:0] == CCR_AUX_PROBE_CODE) & probe_sel;
    aux2_d  = cfg_q[CCR_CFG_PROBE_EN_BIT] &
              (aux_q[7:CCR_AUX_SEL_W] == CCR_AUX_PROBE_CODE) & probe_sel;
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      cfg_q   <= CCR_CFG_RESET;
      cmd_q   <= CCR_CMD_IDLE;
      aux_q   <= CCR_AUX_RESET;
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
      flush_q <= 1'b0;
      pin_q   <= 1'b0;
      oen_q   <= 1'b1;
      gpin_q  <= 1'b0;
      probe_q <= 1'b0;
      aux1_q  <= 1'b0;
      aux2_q  <= 1'b0;
    end else begin
      cfg_q   <= cfg_d;
      cmd_q   <= cmd_d;
      aux_q   <= aux_d;
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
      flush_q <= flush_d;
      pin_q   <= pin_d;
      oen_q   <= oen_d;
      gpin_q  <= gpin_d;
      probe_q <= probe_d;
      aux1_q  <= aux1_d;
      aux2_q  <= aux2_d;
    end
  end

  assign AVS_READDATA_OUT  = rdata_q;
  assign CMD_CODE_OUT      = cmd_q;
  assign FLUSH_PULSE_OUT   = flush_q;
  assign PORT_PIN_OUT      = pin_q;
  assign PORT_PIN_OE_N_OUT = oen_q;
  assign GPIO_PIN_OUT      = gpin_q;
  assign ERROR_PROBE_OUT   = probe_q;
  assign AUX1_OUT          = aux1_q;
  assign AUX2_OUT          = aux2_q;

  property p_ctrl_hold;
    @(posedge CLK_IN) disable iff (RESET_IN)
      !wr_cfg |=> cfg_q == $past(cfg_q);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("config changed without write");

  property p_dyn_clear;
    @(posedge CLK_IN) disable iff (RESET_IN)
      CMD_DONE_IN && !wr_cmd |=> cmd_q == CCR_CMD_IDLE;
  endproperty
  a_dyn_clear: assert property (p_dyn_clear) else $error("command not returned idle");

  property p_status_read;
    @(posedge CLK_IN) disable iff (RESET_IN)
      rd_first && AVS_ADDRESS_IN == CCR_ADDR_STAT |=> AVS_READDATA_OUT == {24'h0, $past(FAULT_IN)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read mismatch");

  property p_wo_zero;
    @(posedge CLK_IN) disable iff (RESET_IN)
      rd_first && AVS_ADDRESS_IN == CCR_ADDR_CMD |=> AVS_READDATA_OUT[31:4] == 28'h0;
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("write-only bit read nonzero");

  property p_sec_clk;
    @(posedge CLK_IN) disable iff (RESET_IN)
      cfg_q[CCR_CFG_CLKSEL_BIT] |=> PORT_PIN_OUT == $past(SEC_CLK_IN) && !PORT_PIN_OE_N_OUT;
  endproperty
  a_sec_clk: assert property (p_sec_clk) else $error("pin not carrying secure clock");

  property p_gpio_mode;
    @(posedge CLK_IN) disable iff (RESET_IN)
      !cfg_q[CCR_CFG_CLKSEL_BIT] |=>
        PORT_PIN_OUT == $past(GPIO_DATA_IN) && PORT_PIN_OE_N_OUT == $past(GPIO_OE_N_IN);
  endproperty
  a_gpio_mode: assert property (p_gpio_mode) else $error("pin not in port mode");

  property p_probe_pad;
    @(posedge CLK_IN) disable iff (RESET_IN)
      cfg_q[CCR_CFG_PROBE_EN_BIT] && aux_q[3:0] == CCR_AUX_PROBE_CODE |=>
        AUX1_OUT == ERROR_PROBE_OUT;
  endproperty
  a_probe_pad: assert property (p_probe_pad) else $error("probe missing on pad one");

  property p_probe_sel;
    @(posedge CLK_IN) disable iff (RESET_IN)
      1'b1 |=> ERROR_PROBE_OUT == $past(FAULT_IN[cfg_q[2:0]]);
  endproperty
  a_probe_sel: assert property (p_probe_sel) else $error("wrong fault selected");

  property p_resv_zero;
    @(posedge CLK_IN) disable iff (RESET_IN)
      rd_first && AVS_ADDRESS_IN == CCR_ADDR_CFG |=> AVS_READDATA_OUT[6:4] == 3'b000;
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved bits nonzero");

  property p_write_wins;
    @(posedge CLK_IN) disable iff (RESET_IN)
      wr_cmd && CMD_DONE_IN |=> cmd_q == $past(AVS_WRITEDATA_IN[3:0]);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("hardware clear beat write");

  property p_probe_pad_two;
    @(posedge CLK_IN) disable iff (RESET_IN)
      cfg_q[CCR_CFG_PROBE_EN_BIT] && aux_q[7:4] == CCR_AUX_PROBE_CODE |=>
        AUX2_OUT == ERROR_PROBE_OUT;
  endproperty
  a_probe_pad_two: assert property (p_probe_pad_two) else $error("probe not on pad two");

  // Pads must stay quiet whenever the probe is disabled
  property p_pads_off;
    @(posedge CLK_IN) disable iff (RESET_IN)
      !cfg_q[CCR_CFG_PROBE_EN_BIT] |=> !AUX1_OUT && !AUX2_OUT;
  endproperty
  a_pads_off: assert property (p_pads_off) else $error("pads active with probe off");

  property p_flush_once;
    @(posedge CLK_IN) disable iff (RESET_IN)
      FLUSH_PULSE_OUT |=> !FLUSH_PULSE_OUT;
  endproperty
  a_flush_once: assert property (p_flush_once) else $error("flush pulse too long");

  property p_cmd_hold;
    @(posedge CLK_IN) disable iff (RESET_IN)
      !wr_cmd && !CMD_DONE_IN |=> $stable(cmd_q);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command changed on its own");

  property p_cfg_resv;
    @(posedge CLK_IN) disable iff (RESET_IN)
      cfg_q[6:4] == 3'b000;
  endproperty
  a_cfg_resv: assert property (p_cfg_resv) else $error("reserved bits stored");

endmodule // ccr_top

/* dv/ccr_cmd_model.sv */
`timescale 1ns/1ps
module ccr_cmd_model (
  input  wire logic       clk_in,   // System clock
  input  wire logic       rst_in,   // Async reset, active high
  input  wire logic [3:0] code_in,  // Command seen by the engine
  input  wire logic [3:0] lat_in,   // Cycles the command runs
  output logic            done_out  // Finish pulse
);
  logic [3:0] cnt_q;
  // Slow or prompt engine, set by lat_in; one pulse per command
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q    <= 4'h0;
      done_out <= 1'b0;
    end else begin
      done_out <= (code_in != 4'h0) && (cnt_q == lat_in) && !done_out;
      cnt_q    <= (code_in == 4'h0 || done_out) ? 4'h0 : cnt_q + 4'h1;
    end
  end
endmodule // ccr_cmd_model

/* dv/ccr_tb_top.sv */
`timescale 1ns/1ps
module ccr_tb_top;
  import ccr_pkg::*;
  logic        clk = 0, rst = 1, rd = 0, wr = 0, sclk = 0, gd = 0, goe = 1, pin = 0;
  logic [15:0] addr = 16'h0;
  logic [31:0] wd = 32'h0, rdat, r;
  logic [3:0]  be = 4'h1, code, lat = 4'h3;
  logic [7:0]  flt = 8'h0, cfg, aux;
  logic        done_in, wt, flush, pout, poe, gpin, prb, a1, a2;
  int          errors = 0, tests_run = 0, flushes = 0;
  always #25 clk = ~clk;
  always @(posedge clk) if (flush === 1'b1) flushes <= flushes + 1;
  ccr_top dut (.CLK_IN(clk), .RESET_IN(rst), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdat),
    .AVS_WAITREQUEST_OUT(wt), .CMD_DONE_IN(done_in), .CMD_CODE_OUT(code),
    .FLUSH_PULSE_OUT(flush), .FAULT_IN(flt), .SEC_CLK_IN(sclk), .GPIO_DATA_IN(gd),
    .GPIO_OE_N_IN(goe), .PORT_PIN_IN(pin), .PORT_PIN_OUT(pout), .PORT_PIN_OE_N_OUT(poe),
    .GPIO_PIN_OUT(gpin), .ERROR_PROBE_OUT(prb), .AUX1_OUT(a1), .AUX2_OUT(a2));
  ccr_cmd_model model (.clk_in(clk), .rst_in(rst), .code_in(code), .lat_in(lat),
    .done_out(done_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Request held until the edge that sees the stall low; data taken there
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd   <= !w;
    wr   <= w;
    addr <= a;
    wd   <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (wt !== 1'b0 && n < 20);
    if (n >= 20) begin
      errors++;
      results();
    end
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  function automatic logic [2:0] pads(input logic [7:0] c, x, f);
    logic p;
    p = f[c[2:0]];
    return {p, p & c[3] & (x[3:0] == 4'ha), p & c[3] & (x[7:4] == 4'ha)};
  endfunction
  initial begin
    void'($urandom(41));
    repeat (2) @(posedge clk);
    chk({31'h0, poe}, 32'h1);
    rst <= 1'b0;
    bus(0, CCR_ADDR_CFG, 8'h0); chk(r, 32'h0);
    bus(0, CCR_ADDR_AUX, 8'h0); chk(r, 32'h0);
    bus(1, CCR_ADDR_CFG, 8'hff);
    bus(0, CCR_ADDR_CFG, 8'h0); chk(r, 32'h8f);
    be <= 4'h0;
    bus(1, CCR_ADDR_CFG, 8'h00);
    be <= 4'h1;
    bus(0, CCR_ADDR_CFG, 8'h0); chk(r, 32'h8f);
    bus(0, 16'h6338, 8'h0); chk(r, 32'h0);
    bus(1, CCR_ADDR_CMD, 8'h80);
    bus(0, CCR_ADDR_CMD, 8'h0); chk(r, 32'h0);
    chk(32'(flushes), 32'h1);
    bus(1, CCR_ADDR_CMD, 8'h05);
    @(negedge clk);
    chk({28'h0, code}, 32'h5);
    repeat (8) @(posedge clk);
    bus(0, CCR_ADDR_CMD, 8'h0); chk(r, 32'h0);
    // Prompt engine: its finish pulse lands on the second write's accept edge
    lat <= 4'h1;
    bus(1, CCR_ADDR_CMD, 8'h05);
    bus(1, CCR_ADDR_CMD, 8'h03);
    @(negedge clk);
    chk({28'h0, code}, 32'h3);
    repeat (4) @(posedge clk);
    bus(0, CCR_ADDR_CMD, 8'h0); chk(r, 32'h0);
    flt <= 8'($urandom());
    bus(1, CCR_ADDR_STAT, 8'h00);
    bus(0, CCR_ADDR_STAT, 8'h0); chk(r, {24'h0, flt});
    for (int i = 0; i < 32; i++) begin
      cfg = 8'($urandom());
      cfg[2:0] = i[2:0];
      aux = 8'($urandom());
      if (i[3]) aux[3:0] = 4'ha;
      if (i[3]) cfg[3] = 1'b1;
      if (i[4]) aux[7:4] = 4'ha;
      bus(1, CCR_ADDR_AUX, aux);
      bus(1, CCR_ADDR_CFG, cfg);
      bus(0, CCR_ADDR_CFG, 8'h0); chk(r, {24'h0, cfg & 8'h8f});
      flt  <= 8'($urandom());
      sclk <= 1'($urandom());
      gd   <= 1'($urandom());
      goe  <= 1'($urandom());
      pin  <= 1'($urandom());
      @(posedge clk);
      @(negedge clk);
      chk({29'h0, prb, a1, a2}, {29'h0, pads(cfg, aux, flt)});
      chk({30'h0, pout, poe}, cfg[7] ? {30'h0, sclk, 1'b0} : {30'h0, gd, goe});
      chk({31'h0, gpin}, {31'h0, pin});
    end
    // Reset again mid-run; configuration must come back cleared
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    bus(0, CCR_ADDR_CFG, 8'h0); chk(r, 32'h0);
    results();
  end
endmodule // ccr_tb_top
